// >>> hdl/frame_sync_port_regs.svh
// timing constants and reset levels of the frame sync port
`ifndef FRAME_SYNC_PORT_REGS_SVH
`define FRAME_SYNC_PORT_REGS_SVH
`define FSP_CLK_PERIOD_NS 10
`define FSP_FR_LOW_TIME_NS 1000000
`define FSP_TERM_TIME_NS 10000000
`define FSP_FIRST_DELAY_TIME_NS 2000
`define FSP_PIN_IDLE_LEVEL 1'b1
`define FSP_CNT_W 32
`endif

// >>> hdl/frame_sync_pkg.sv
// types shared by the frame sync port modules
package frame_sync_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_DELAY,
    SEQ_MARK_HI,
    SEQ_MARK_LO,
    SEQ_TERM
  } seq_state_t;
endpackage

// >>> hdl/edge_event_if.sv
// carries a falling-edge event as a toggle from the link domain
`timescale 1ns/10ps
interface edge_event_if;
  logic toggle;
  modport src (output toggle);
  modport dst (input toggle);
endinterface

// >>> hdl/edge_catcher.sv
// link-domain input synchroniser and falling edge toggle source
`timescale 1ns/10ps
`include "frame_sync_port_regs.svh"
module edge_catcher (
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  edge_event_if.src evt
);
  logic s1_reg, s2_reg, s3_reg;
  logic stable_reg;
  logic toggle_reg;

  // three-stage synchroniser, idle high out of reset
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= `FSP_PIN_IDLE_LEVEL;
      s2_reg <= `FSP_PIN_IDLE_LEVEL;
      s3_reg <= `FSP_PIN_IDLE_LEVEL;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a level counts once stages two and three agree
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_reg <= `FSP_PIN_IDLE_LEVEL;
      toggle_reg <= 1'b0;
    end else if (s2_reg == s3_reg && s3_reg != stable_reg) begin
      stable_reg <= s3_reg;
      if (!s3_reg) begin
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  assign evt.toggle = toggle_reg;
endmodule

// >>> hdl/frame_sync_port.sv
// sync port: frame clock, marker strobe and collection outputs, edge inputs
//
// Functional notes
// - once set up, the frame clock output goes low for 1 ms at each frame start.
// - each frame carries one strobe per marker activation, then one 10 ms termination pulse.
// - the first strobe of a frame starts a short nonzero delay after the frame clock pulse begins.
// - the collection-active output is low for the whole collection and high after it.
// - frame clock and collection-active are active low, the strobe active high, all open collector.
// - a collection starts only on a falling edge of the collection trigger input.
// - with external framing each falling edge of the frame clock input starts a frame.
// - undriven inputs read as idle high and produce no event.
// - a varying external frame period is followed, each edge starting a frame.
// - the recorded frame frequency is the configured setting, not the measured rate.
`timescale 1ns/10ps
`include "frame_sync_port_regs.svh"
module frame_sync_port #(
  parameter int CNT_W = `FSP_CNT_W,
  parameter int FR_LOW_CYCLES = `FSP_FR_LOW_TIME_NS / `FSP_CLK_PERIOD_NS,
  parameter int TERM_CYCLES = `FSP_TERM_TIME_NS / `FSP_CLK_PERIOD_NS,
  parameter int MARK_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic frame_clock_in_i,
  input wire logic collection_trigger_in_i,
  input wire logic collection_setup_i,
  input wire logic external_framing_i,
  input wire logic [MARK_W-1:0] marker_count_i,
  input wire logic [CNT_W-1:0] marker_period_cycles_i,
  input wire logic [CNT_W-1:0] marker_high_cycles_i,
  input wire logic [CNT_W-1:0] frame_period_cycles_i,
  input wire logic [CNT_W-1:0] frames_to_collect_i,
  output logic frame_clock_out_o,
  output logic frame_clock_out_oe_o,
  output logic marker_strobe_out_o,
  output logic marker_strobe_out_oe_o,
  output logic collection_active_out_o,
  output logic collection_active_out_oe_o,
  output logic [CNT_W-1:0] recorded_frame_period_o,
  output frame_sync_pkg::seq_state_t seq_state_o
);
  import frame_sync_pkg::*;

  // first strobe delay in device cycles, rounded up
  localparam int DELAY_CYCLES_I =
    (`FSP_FIRST_DELAY_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS;

  // counter load values, one less than the cycle count
  localparam logic [CNT_W-1:0] DELAY_LOAD = CNT_W'(DELAY_CYCLES_I - 1);
  localparam logic [CNT_W-1:0] FR_LOW_LOAD = CNT_W'(FR_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] TERM_LOAD = CNT_W'(TERM_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [MARK_W-1:0] MARK_ONE = MARK_W'(1);

  // toggle carriers out of the link domain
  edge_event_if fr_evt ();
  edge_event_if tr_evt ();

  // crossing, sequencer and collection state
  logic [2:0] fr_sync_reg, tr_sync_reg;
  logic fr_seen_reg, tr_seen_reg;
  logic fr_fall, tr_fall;
  logic [CNT_W-1:0] int_cnt_reg;
  logic frame_start;
  seq_state_t state_reg;
  logic [CNT_W-1:0] seq_cnt_reg;
  logic [MARK_W-1:0] marks_left_reg;
  logic frame_done;
  logic strobe_on;
  logic coll_start;
  logic [CNT_W-1:0] fr_cnt_reg;
  logic fr_low_reg;
  logic collecting_reg;
  logic [CNT_W-1:0] frames_left_reg;

  // link-domain edge catchers for the two inputs
  edge_catcher u_fr_catch (
    .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(frame_clock_in_i),
    .evt(fr_evt.src)
  );
  edge_catcher u_tr_catch (
    .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(collection_trigger_in_i),
    .evt(tr_evt.src)
  );

  // frame toggle crosses into clk_i through three stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fr_sync_reg <= 3'h0;
      fr_seen_reg <= 1'b0;
    end else begin
      fr_sync_reg <= {fr_sync_reg[1:0], fr_evt.toggle};
      if (fr_fall) begin
        fr_seen_reg <= fr_sync_reg[2];
      end
    end
  end

  // trigger toggle crosses into clk_i through three stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tr_sync_reg <= 3'h0;
      tr_seen_reg <= 1'b0;
    end else begin
      tr_sync_reg <= {tr_sync_reg[1:0], tr_evt.toggle};
      if (tr_fall) begin
        tr_seen_reg <= tr_sync_reg[2];
      end
    end
  end

  // frame event per agreed toggle change
  assign fr_fall = (fr_sync_reg[1] == fr_sync_reg[2]) && (fr_sync_reg[2] != fr_seen_reg);

  // trigger event per agreed toggle change
  assign tr_fall = (tr_sync_reg[1] == tr_sync_reg[2]) && (tr_sync_reg[2] != tr_seen_reg);

  // internal frame timer, idle under external framing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_cnt_reg <= '0;
    end else if (!collection_setup_i || external_framing_i) begin
      int_cnt_reg <= '0;
    end else if (int_cnt_reg == CNT_ZERO) begin
      int_cnt_reg <= frame_period_cycles_i - CNT_ONE;
    end else begin
      int_cnt_reg <= int_cnt_reg - CNT_ONE;
    end
  end

  // each external edge restarts the frame, whatever its spacing
  assign frame_start = collection_setup_i &&
    (external_framing_i ? fr_fall : (int_cnt_reg == CNT_ZERO));

  // marker strobe sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SEQ_IDLE;
      seq_cnt_reg <= '0;
    end else if (!collection_setup_i) begin
      state_reg <= SEQ_IDLE;
      seq_cnt_reg <= '0;
    end else if (frame_start) begin
      state_reg <= SEQ_DELAY;
      seq_cnt_reg <= DELAY_LOAD;
    end else if (seq_cnt_reg != CNT_ZERO) begin
      seq_cnt_reg <= seq_cnt_reg - CNT_ONE;
    end else begin
      unique case (state_reg)
        SEQ_IDLE: begin
          state_reg <= SEQ_IDLE;
        end
        SEQ_DELAY, SEQ_MARK_LO: begin
          if (marks_left_reg != '0) begin
            state_reg <= SEQ_MARK_HI;
            seq_cnt_reg <= marker_high_cycles_i - CNT_ONE;
          end else begin
            state_reg <= SEQ_TERM;
            seq_cnt_reg <= TERM_LOAD;
          end
        end
        SEQ_MARK_HI: begin
          state_reg <= SEQ_MARK_LO;
          seq_cnt_reg <= marker_period_cycles_i - marker_high_cycles_i - CNT_ONE;
        end
        SEQ_TERM: begin
          state_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // markers still due in this frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      marks_left_reg <= '0;
    end else if (!collection_setup_i) begin
      marks_left_reg <= '0;
    end else if (frame_start) begin
      marks_left_reg <= marker_count_i;
    end else if (seq_cnt_reg == CNT_ZERO && state_reg == SEQ_MARK_HI) begin
      marks_left_reg <= marks_left_reg - MARK_ONE;
    end
  end

  // strobe or termination pulse in progress
  assign strobe_on = (state_reg == SEQ_MARK_HI) || (state_reg == SEQ_TERM);

  // last cycle of an unbroken termination pulse
  assign frame_done = collection_setup_i && !frame_start && state_reg == SEQ_TERM && seq_cnt_reg == CNT_ZERO;

  // frame clock window counter from each frame start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fr_cnt_reg <= '0;
    end else if (!collection_setup_i) begin
      fr_cnt_reg <= '0;
    end else if (frame_start) begin
      fr_cnt_reg <= FR_LOW_LOAD;
    end else if (fr_cnt_reg != CNT_ZERO) begin
      fr_cnt_reg <= fr_cnt_reg - CNT_ONE;
    end
  end

  // frame clock low until the window counter runs out
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fr_low_reg <= 1'b0;
    end else if (!collection_setup_i) begin
      fr_low_reg <= 1'b0;
    end else if (frame_start) begin
      fr_low_reg <= 1'b1;
    end else if (fr_cnt_reg == CNT_ZERO) begin
      fr_low_reg <= 1'b0;
    end
  end

  // trigger edge opens a collection only when idle and frames are asked for
  assign coll_start = collection_setup_i && !collecting_reg && tr_fall &&
    frames_to_collect_i != CNT_ZERO;

  // collection runs from the trigger edge until the last counted frame ends
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      collecting_reg <= 1'b0;
    end else if (!collection_setup_i) begin
      collecting_reg <= 1'b0;
    end else if (coll_start) begin
      collecting_reg <= 1'b1;
    end else if (collecting_reg && frame_done && frames_left_reg == CNT_ONE) begin
      collecting_reg <= 1'b0;
    end
  end

  // frames still to be counted in this collection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frames_left_reg <= '0;
    end else if (!collection_setup_i) begin
      frames_left_reg <= '0;
    end else if (coll_start) begin
      frames_left_reg <= frames_to_collect_i;
    end else if (collecting_reg && frame_done) begin
      frames_left_reg <= frames_left_reg - CNT_ONE;
    end
  end

  // configured period kept with the collection, never a measured rate
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recorded_frame_period_o <= '0;
    end else if (coll_start) begin
      recorded_frame_period_o <= frame_period_cycles_i;
    end
  end

  // frame clock pin, pulled low during the window
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_clock_out_o <= 1'b1;
      frame_clock_out_oe_o <= 1'b0;
    end else begin
      frame_clock_out_o <= !fr_low_reg;
      frame_clock_out_oe_o <= fr_low_reg;
    end
  end

  // strobe pin, released high while a pulse runs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      marker_strobe_out_o <= 1'b0;
      marker_strobe_out_oe_o <= 1'b1;
    end else begin
      marker_strobe_out_o <= strobe_on;
      marker_strobe_out_oe_o <= !strobe_on;
    end
  end

  // collection pin, pulled low for the whole collection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      collection_active_out_o <= 1'b1;
      collection_active_out_oe_o <= 1'b0;
    end else begin
      collection_active_out_o <= !collecting_reg;
      collection_active_out_oe_o <= collecting_reg;
    end
  end

  // sequencer state mirror for observation
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_state_o <= SEQ_IDLE;
    end else begin
      seq_state_o <= state_reg;
    end
  end
endmodule

// >>> verif/frame_sync_port_props.sv
// checker of the frame sync port pin behaviour
`timescale 1ns/10ps
module frame_sync_port_props #(
  parameter int CNT_W = 32,
  parameter int FR_LOW_CYCLES = 50,
  parameter int TERM_CYCLES = 40
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic collection_setup_i,
  input wire logic [CNT_W-1:0] marker_high_cycles_i,
  input wire logic [CNT_W-1:0] frame_period_cycles_i,
  input wire logic frame_clock_out_o,
  input wire logic frame_clock_out_oe_o,
  input wire logic marker_strobe_out_o,
  input wire logic marker_strobe_out_oe_o,
  input wire logic collection_active_out_o,
  input wire logic collection_active_out_oe_o,
  input wire logic [CNT_W-1:0] recorded_frame_period_o
);
  logic [CNT_W-1:0] fr_cnt_reg;
  logic [CNT_W-1:0] hi_cnt_reg;
  // run lengths of the frame pulse and strobe pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fr_cnt_reg <= '0;
      hi_cnt_reg <= '0;
    end else begin
      fr_cnt_reg <= frame_clock_out_oe_o ? fr_cnt_reg + 1'b1 : '0;
      hi_cnt_reg <= marker_strobe_out_o ? hi_cnt_reg + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_fr_pol; frame_clock_out_o == !frame_clock_out_oe_o; endproperty
  a_fr_pol: assert property (p_fr_pol) else $error("frame pin level wrong");
  property p_st_pol; marker_strobe_out_o == !marker_strobe_out_oe_o; endproperty
  a_st_pol: assert property (p_st_pol) else $error("strobe pin level wrong");
  property p_ca_pol; collection_active_out_o == !collection_active_out_oe_o; endproperty
  a_ca_pol: assert property (p_ca_pol) else $error("active pin level wrong");
  property p_fr_width; $fell(frame_clock_out_oe_o) |-> fr_cnt_reg == FR_LOW_CYCLES; endproperty
  a_fr_width: assert property (p_fr_width) else $error("frame pulse width wrong");
  property p_gap; $rose(frame_clock_out_oe_o) |-> !marker_strobe_out_o [*8]; endproperty
  a_gap: assert property (p_gap) else $error("strobe meets frame pulse");
  property p_st_w;
    $fell(marker_strobe_out_o) |-> hi_cnt_reg == marker_high_cycles_i || hi_cnt_reg == TERM_CYCLES;
  endproperty
  a_st_w: assert property (p_st_w) else $error("strobe width wrong");
  property p_clear;
    !collection_setup_i [*4] |-> !frame_clock_out_oe_o && !collection_active_out_oe_o;
  endproperty
  a_clear: assert property (p_clear) else $error("outputs active without setup");
  property p_rec; $rose(collection_active_out_oe_o) |-> recorded_frame_period_o == frame_period_cycles_i; endproperty
  a_rec: assert property (p_rec) else $error("recorded period wrong");
  c_frame: cover property ($rose(frame_clock_out_oe_o));
  c_term: cover property ($fell(marker_strobe_out_o) && hi_cnt_reg == TERM_CYCLES);
  c_coll: cover property ($fell(collection_active_out_oe_o));
endmodule

// >>> verif/lab_equipment_model.sv
// external equipment making high-to-low edges on the two inputs
`timescale 1ns/10ps
module lab_equipment_model (
  input wire logic link_clk_i,
  input wire logic [1:0] req_i,
  output logic [1:0] pin_o
);
  logic [1:0] seen_reg = 2'h0;
  int low_reg [2] = '{0, 0};
  // each request toggle pulls its pin low for four link cycles
  always @(posedge link_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      seen_reg[i] <= req_i[i];
      low_reg[i] <= (req_i[i] != seen_reg[i]) ? 4 : (low_reg[i] > 0 ? low_reg[i] - 1 : 0);
    end
  end
  // released pins sit at the pull-up level
  always_comb pin_o = {low_reg[1] == 0, low_reg[0] == 0};
endmodule

// >>> verif/test_frame_sync_port.sv
// self-checking bench of the frame sync port
`timescale 1ns/10ps
module test_frame_sync_port;
  import frame_sync_pkg::*;
  logic clk_i = 0, link_clk_i = 0, rst_n_i = 0, setup = 0, ext = 1;
  logic [1:0] req = 2'h0;
  logic [1:0] pin;
  logic [31:0] nfr = 32'h0;
  logic [7:0] nmark = 8'h02;
  logic [31:0] rec;
  logic fr, fr_oe, st, st_oe, ca, ca_oe;
  seq_state_t state;
  int err_count = 0;
  int checks_done = 0;
  frame_sync_port #(.FR_LOW_CYCLES(50), .TERM_CYCLES(40)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link_clk_i(link_clk_i), .frame_clock_in_i(pin[0]), .collection_trigger_in_i(pin[1]),
    .collection_setup_i(setup), .external_framing_i(ext), .marker_count_i(nmark),
    .marker_period_cycles_i(32'hA), .marker_high_cycles_i(32'h5), .frame_period_cycles_i(32'h190),
    .frames_to_collect_i(nfr), .frame_clock_out_o(fr), .frame_clock_out_oe_o(fr_oe),
    .marker_strobe_out_o(st), .marker_strobe_out_oe_o(st_oe), .collection_active_out_o(ca),
    .collection_active_out_oe_o(ca_oe), .recorded_frame_period_o(rec), .seq_state_o(state));
  lab_equipment_model peer (.link_clk_i(link_clk_i), .req_i(req), .pin_o(pin));
  always #5 clk_i = ~clk_i;
  // link clock, free running and out of phase
  initial begin
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait for a level, giving the cycles spent
  task automatic await(ref logic s, input logic v, output int n);
    n = 0;
    while (s !== v) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 3000) begin
        check(1'b0, "wait ran out");
        final_report();
      end
    end
  endtask
  // strobe rises and last high width over a window
  task automatic watch(input int cyc, output int r, output int w);
    logic prev;
    r = 0;
    w = 0;
    prev = st;
    repeat (cyc) begin
      @(posedge clk_i);
      #1;
      if (st === 1'b1 && prev !== 1'b1) r++;
      if (st === 1'b1 && prev !== 1'b1) w = 0;
      if (st === 1'b1) w++;
      prev = st;
    end
  endtask
  task automatic pulse_in(input int i);
    @(posedge clk_i);
    req[i] <= ~req[i];
  endtask
  task automatic t_frame();
    int n, r, w;
    check(fr === 1'b1 && fr_oe === 1'b0 && st_oe === 1'b1 && ca === 1'b1, "idle pins");
    check(state === SEQ_IDLE, "event from idle inputs");
    @(posedge clk_i);
    setup <= 1'b1;
    pulse_in(0);
    await(fr_oe, 1'b1, n);
    check(fr === 1'b0, "frame pin not low");
    await(st, 1'b1, n);
    check(n > 0 && fr_oe === 1'b0, "strobe too early");
    watch(300, r, w);
    check(r == 2 && w == 40, "strobe train wrong");
  endtask
  task automatic t_vary();
    int r, w;
    int gap [2] = '{330, 520};
    foreach (gap[i]) begin
      pulse_in(0);
      watch(gap[i], r, w);
      check(r == 3 && w == 40, "frame not rerun");
    end
    @(posedge clk_i);
    nmark <= 8'h00;
    pulse_in(0);
    watch(330, r, w);
    check(r == 1 && w == 40, "markerless frame wrong");
  endtask
  task automatic t_collect();
    int n;
    @(posedge clk_i);
    ext <= 1'b0;
    nmark <= 8'h02;
    pulse_in(1);
    repeat (100) @(posedge clk_i);
    check(ca === 1'b1, "trigger taken with no frames");
    nfr <= 32'h2;
    pulse_in(1);
    await(ca_oe, 1'b1, n);
    check(ca === 1'b0 && rec === 32'h190, "collection start wrong");
    await(ca_oe, 1'b0, n);
    check(n > 390 && n < 810 && ca === 1'b1, "collection length wrong");
    @(posedge clk_i);
    ext <= 1'b1;
    setup <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(fr_oe === 1'b0 && ca === 1'b1, "outputs left active");
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    t_frame();
    t_vary();
    t_collect();
    final_report();
  end
endmodule
bind frame_sync_port frame_sync_port_props #(.CNT_W(CNT_W), .FR_LOW_CYCLES(FR_LOW_CYCLES),
  .TERM_CYCLES(TERM_CYCLES)) chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .collection_setup_i(collection_setup_i),
  .marker_high_cycles_i(marker_high_cycles_i), .frame_period_cycles_i(frame_period_cycles_i),
  .frame_clock_out_o(frame_clock_out_o), .frame_clock_out_oe_o(frame_clock_out_oe_o),
  .marker_strobe_out_o(marker_strobe_out_o), .marker_strobe_out_oe_o(marker_strobe_out_oe_o),
  .collection_active_out_o(collection_active_out_o), .collection_active_out_oe_o(collection_active_out_oe_o),
  .recorded_frame_period_o(recorded_frame_period_o));
